/* hw/pmirq_registers.sv */
// Interrupt, mask, mode and step-rate register block of the power device
// Functional notes
// [R1] Second flag register reads, then clears
// [R2] Short and power-good-lost events set bits 7..4
// [R3] Input over/under-voltage set bits 3, 2
// [R4] Thermal bit 1, fault pin fall bit 0
// [R5] Mask one bits 7..5 hold over-current flags
// [R6] Mask one bits 4..0 hold overvolt/short flags
// [R7] Mask two bits 7..4 hold their flags
// [R8] Mask two bits 3..0 hold; masks reset zero
// [R9] Fault pin enable resets to one
// [R10] Discharge enables per rail, reset off
// [R11] Bias enable bit 3, reset off
// [R12] Rail enables bits 2..0, reset off
// [R13] Soft reset restores every field
// [R14] Fault pin trigger sets forced shutdown latch
// [R15] Latch writable only while pin high
// [R16] Negative rail step time bits 5..3
// [R17] Positive rail step time bits 2..0
// [R18] First flag register mirrors mask one bits
// [R19] Status bit shows live fault pin level
// [R20] Flags stay set until read
`default_nettype none
`include "pmirq_regs.svh"
module pmirq_registers
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic [7:0] fault_one_events,
   input  wire logic [6:0] fault_two_events,
   input  wire logic [6:0] live_status,
   input  wire logic       fault_input_pin,
   output logic      [7:0] reg_rdata,
   output logic            fault_pin_enable,
   output logic      [2:0] discharge_en,
   output logic            bias_enable,
   output logic      [2:0] rail_enable,
   output logic            forced_shutdown_latch,
   output logic      [2:0] neg_rail_step_time,
   output logic      [2:0] pos_rail_step_time,
   output logic            pos_rail_step_tick,
   output logic            neg_rail_step_tick
);
   logic [7:0] interrupt_mask_one;
   logic [7:0] interrupt_mask_two;
   logic [7:0] mode_control_one;
   logic [7:0] mode_control_two;
   logic [7:0] scaling_step_rate;
   logic [7:0] interrupt_flags_one;
   logic [7:0] interrupt_flags_two;
   logic       soft_rst;
   logic       pin_last;
   logic       pin_fall;
   logic [7:0] events_two;
   logic       rd_flags_one;
   logic       rd_flags_two;
   logic [7:0] next_rdata;

   // Register write decode, shared by every writable register
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // ==========================================================
   // Soft reset pulse and fault pin edge
   // [R13] soft reset pulse
   assign soft_rst = reg_wr && hit(reg_addr, `PMIRQ_OFF_MODE_TWO)
                     && reg_wdata[`PMIRQ_BIT_SOFT_RST];
   // [R4] falling pin edge, only when pin function is on
   assign pin_fall = pin_last && !fault_input_pin && mode_control_one[`PMIRQ_BIT_FAULT_EN];
   // [R2] [R3] flag two event map, pin fall at bit 0
   assign events_two = {fault_two_events, pin_fall};
   assign rd_flags_one = reg_rd && hit(reg_addr, `PMIRQ_OFF_FLAGS_ONE);
   assign rd_flags_two = reg_rd && hit(reg_addr, `PMIRQ_OFF_FLAGS_TWO);

   // Pin history; seeded high so a pin already low after reset gives a fall
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         pin_last <= 1'b1;
      else
         pin_last <= fault_input_pin;
   end

   // ==========================================================
   // Flag registers
   // [R18] [R5] [R6] first flag bank
   pmirq_flag_bank u_flags_one
   (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .soft_rst   (soft_rst),
      .event_in   (fault_one_events),
      .mask       (interrupt_mask_one),
      .read_clear (rd_flags_one),
      .flags      (interrupt_flags_one)
   );
   // [R1] [R7] [R8] [R20] second flag bank
   pmirq_flag_bank u_flags_two
   (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .soft_rst   (soft_rst),
      .event_in   (events_two),
      .mask       (interrupt_mask_two),
      .read_clear (rd_flags_two),
      .flags      (interrupt_flags_two)
   );

   // ==========================================================
   // Mask registers
   // [R8] masks reset to zero
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         interrupt_mask_one <= `PMIRQ_RST_MASK;
         interrupt_mask_two <= `PMIRQ_RST_MASK;
      end
      else if (soft_rst)
      begin
         interrupt_mask_one <= `PMIRQ_RST_MASK;
         interrupt_mask_two <= `PMIRQ_RST_MASK;
      end
      else if (reg_wr)
      begin
         if (hit(reg_addr, `PMIRQ_OFF_MASK_ONE))
            interrupt_mask_one <= reg_wdata;
         if (hit(reg_addr, `PMIRQ_OFF_MASK_TWO))
            interrupt_mask_two <= reg_wdata;
      end
   end

   // ==========================================================
   // Mode control one and step rate
   // [R9] [R10] [R11] [R12] [R16] [R17] plain read-write fields
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_control_one  <= `PMIRQ_RST_MODE_ONE;
         scaling_step_rate <= `PMIRQ_RST_STEP_RATE;
      end
      else if (soft_rst)
      begin
         mode_control_one  <= `PMIRQ_RST_MODE_ONE;
         scaling_step_rate <= `PMIRQ_RST_STEP_RATE;
      end
      else if (reg_wr)
      begin
         if (hit(reg_addr, `PMIRQ_OFF_MODE_ONE))
            mode_control_one <= reg_wdata;
         if (hit(reg_addr, `PMIRQ_OFF_STEP_RATE))
            scaling_step_rate <= reg_wdata;
      end
   end

   // ==========================================================
   // Mode control two; soft reset bit is self clearing
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         mode_control_two <= `PMIRQ_RST_MODE_TWO;
      else if (soft_rst)
         mode_control_two <= `PMIRQ_RST_MODE_TWO;
      else
      begin
         if (reg_wr && hit(reg_addr, `PMIRQ_OFF_MODE_TWO))
         begin
            mode_control_two[6:1] <= reg_wdata[6:1];
            // [R15] latch write honoured only while pin high
            if (fault_input_pin)
               mode_control_two[`PMIRQ_BIT_FORCED] <= reg_wdata[`PMIRQ_BIT_FORCED];
         end
         // [R14] trigger sets latch, winning over a write
         if (pin_fall)
            mode_control_two[`PMIRQ_BIT_FORCED] <= 1'b1;
      end
   end

   // ==========================================================
   // Read mux; unmapped offsets read zero
   always_comb
   begin
      next_rdata = 8'h00;
      unique case (reg_addr)
         `PMIRQ_OFF_STATUS_TWO: next_rdata = {live_status, fault_input_pin}; // [R19]
         `PMIRQ_OFF_FLAGS_ONE:  next_rdata = interrupt_flags_one;
         `PMIRQ_OFF_FLAGS_TWO:  next_rdata = interrupt_flags_two;
         `PMIRQ_OFF_MASK_ONE:   next_rdata = interrupt_mask_one;
         `PMIRQ_OFF_MASK_TWO:   next_rdata = interrupt_mask_two;
         `PMIRQ_OFF_MODE_ONE:   next_rdata = mode_control_one;
         `PMIRQ_OFF_MODE_TWO:   next_rdata = mode_control_two;
         `PMIRQ_OFF_STEP_RATE:  next_rdata = scaling_step_rate;
         default:               next_rdata = 8'h00;
      endcase
   end

   // Read data registered; it shows the value before the clear
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= next_rdata;
   end

   // ==========================================================
   // Control outputs, registered copies of the fields
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fault_pin_enable      <= 1'b1;
         discharge_en          <= 3'h0;
         bias_enable           <= 1'b0;
         rail_enable           <= 3'h0;
         forced_shutdown_latch <= 1'b0;
         neg_rail_step_time    <= `PMIRQ_STEP_40US;
         pos_rail_step_time    <= `PMIRQ_STEP_40US;
      end
      else
      begin
         fault_pin_enable      <= mode_control_one[`PMIRQ_BIT_FAULT_EN];
         discharge_en          <= mode_control_one[6:4];
         bias_enable           <= mode_control_one[3];
         rail_enable           <= mode_control_one[2:0];
         forced_shutdown_latch <= mode_control_two[`PMIRQ_BIT_FORCED];
         neg_rail_step_time    <= scaling_step_rate[5:3];
         pos_rail_step_time    <= scaling_step_rate[2:0];
      end
   end

   // ==========================================================
   // Step tick timers for the two scaled rails
   pmirq_step_timer u_pos_step
   (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .run       (rail_enable[2]),
      .code      (pos_rail_step_time),
      .step_tick (pos_rail_step_tick)
   );
   pmirq_step_timer u_neg_step
   (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .run       (rail_enable[1]),
      .code      (neg_rail_step_time),
      .step_tick (neg_rail_step_tick)
   );

   // ==========================================================
   // Assertions
   property p_flag_read_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      (rd_flags_two && !soft_rst && events_two == 8'h00) |=> interrupt_flags_two == 8'h00;
   endproperty
   a_flag_read_clear: assert property (p_flag_read_clear) // [R1]
      else $error("flag two not cleared by read");

   property p_event_sets;
      @(posedge ref_clk) disable iff (!rst_n)
      (!soft_rst && fault_two_events[6] && !interrupt_mask_two[7]) |=> interrupt_flags_two[7];
   endproperty
   a_event_sets: assert property (p_event_sets) // [R2]
      else $error("short event did not set flag");

   property p_pin_fall_sets;
      @(posedge ref_clk) disable iff (!rst_n)
      (!soft_rst && pin_fall && !interrupt_mask_two[0]) |=> interrupt_flags_two[0];
   endproperty
   a_pin_fall_sets: assert property (p_pin_fall_sets) // [R4]
      else $error("pin fall did not set flag");

   property p_mask_holds;
      @(posedge ref_clk) disable iff (!rst_n)
      (!soft_rst && !rd_flags_one && interrupt_mask_one[7]) |=>
         interrupt_flags_one[7] == $past(interrupt_flags_one[7]);
   endproperty
   a_mask_holds: assert property (p_mask_holds) // [R5]
      else $error("masked flag changed");

   property p_soft_reset;
      @(posedge ref_clk) disable iff (!rst_n)
      soft_rst |=> mode_control_one == 8'h80 && scaling_step_rate == 8'h1b
                   && interrupt_mask_two == 8'h00 ##1 fault_pin_enable;
   endproperty
   a_soft_reset: assert property (p_soft_reset) // [R13]
      else $error("soft reset did not restore fields");

   property p_latch_set;
      @(posedge ref_clk) disable iff (!rst_n)
      (pin_fall && !soft_rst) |=> ##1 forced_shutdown_latch;
   endproperty
   a_latch_set: assert property (p_latch_set) // [R14]
      else $error("forced latch not set by trigger");

   property p_latch_locked;
      @(posedge ref_clk) disable iff (!rst_n)
      (!fault_input_pin && !pin_fall && !soft_rst) |=>
         $stable(mode_control_two[`PMIRQ_BIT_FORCED]);
   endproperty
   a_latch_locked: assert property (p_latch_locked) // [R15]
      else $error("forced latch changed while pin low");

   property p_flag_sticky;
      @(posedge ref_clk) disable iff (!rst_n)
      (interrupt_flags_two[3] && !rd_flags_two && !soft_rst) |=> interrupt_flags_two[3];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) // [R20]
      else $error("flag dropped without read");

   property p_rail_out;
      @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> rail_enable == $past(mode_control_one[2:0])
               && bias_enable == $past(mode_control_one[3]);
   endproperty
   a_rail_out: assert property (p_rail_out) // [R12]
      else $error("rail enable output mismatch");

   c_read_clear: cover property (@(posedge ref_clk) disable iff (!rst_n)
      interrupt_flags_two != 8'h00 && rd_flags_two);
   c_pin_fall: cover property (@(posedge ref_clk) disable iff (!rst_n) pin_fall);
   c_soft_rst: cover property (@(posedge ref_clk) disable iff (!rst_n) soft_rst);
   c_step_tick: cover property (@(posedge ref_clk) disable iff (!rst_n) pos_rail_step_tick);
endmodule : pmirq_registers
`default_nettype wire

/* hw/pmirq_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef PMIRQ_REGS_SVH
`define PMIRQ_REGS_SVH
// ==========================================================
// Register offsets
`define PMIRQ_OFF_FLAGS_ONE   8'h0b
`define PMIRQ_OFF_FLAGS_TWO   8'h0c
`define PMIRQ_OFF_MASK_ONE    8'h0d
`define PMIRQ_OFF_MASK_TWO    8'h0e
`define PMIRQ_OFF_MODE_ONE    8'h0f
`define PMIRQ_OFF_MODE_TWO    8'h10
`define PMIRQ_OFF_STEP_RATE   8'h11
`define PMIRQ_OFF_STATUS_TWO  8'h0a
// ==========================================================
// Reset values
`define PMIRQ_RST_FLAGS       8'h00
`define PMIRQ_RST_MASK        8'h00
`define PMIRQ_RST_MODE_ONE    8'h80
`define PMIRQ_RST_MODE_TWO    8'h00
`define PMIRQ_RST_STEP_RATE   8'h1b
// ==========================================================
// Field positions
`define PMIRQ_BIT_FAULT_EN    7
`define PMIRQ_BIT_SOFT_RST    7
`define PMIRQ_BIT_FORCED      0
`define PMIRQ_BIT_FAULT_IRQ   0
// ==========================================================
// Step time codes and their times in microseconds
`define PMIRQ_STEP_30US       3'h2
`define PMIRQ_STEP_40US       3'h3
`define PMIRQ_STEP_80US       3'h7
`define PMIRQ_STEP_30_TIME_US 30
`define PMIRQ_STEP_40_TIME_US 40
`define PMIRQ_STEP_80_TIME_US 80
`define PMIRQ_CLK_MHZ         50
`define PMIRQ_STEP_30_CYC     (`PMIRQ_STEP_30_TIME_US * `PMIRQ_CLK_MHZ)
`define PMIRQ_STEP_40_CYC     (`PMIRQ_STEP_40_TIME_US * `PMIRQ_CLK_MHZ)
`define PMIRQ_STEP_80_CYC     (`PMIRQ_STEP_80_TIME_US * `PMIRQ_CLK_MHZ)
`endif

/* hw/pmirq_pkg.sv */
// Types shared by the register block
`default_nettype none
package pmirq_pkg;
   // Step tick state, Gray path idle -> count -> tick
   typedef enum logic [1:0]
   {
      PMIRQ_ST_IDLE  = 2'b00,
      PMIRQ_ST_COUNT = 2'b01,
      PMIRQ_ST_TICK  = 2'b11
   } pmirq_step_state_type;
endpackage : pmirq_pkg
`default_nettype wire

/* hw/pmirq_flag_bank.sv */
// Eight sticky read-to-clear interrupt flags with per-bit masks
`default_nettype none
`include "pmirq_regs.svh"
module pmirq_flag_bank
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       soft_rst,
   input  wire logic [7:0] event_in,
   input  wire logic [7:0] mask,
   input  wire logic       read_clear,
   output var  logic [7:0] flags
);
   // ==========================================================
   // Flag storage; a set in the clearing cycle wins
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         flags <= `PMIRQ_RST_FLAGS;
      else if (soft_rst)
         flags <= `PMIRQ_RST_FLAGS;
      else
         flags <= (read_clear ? 8'h00 : flags) | (event_in & ~mask);
   end
endmodule : pmirq_flag_bank
`default_nettype wire

/* hw/pmirq_step_timer.sv */
// Step tick generator for one rail's voltage-scaling slew
`default_nettype none
`include "pmirq_regs.svh"
module pmirq_step_timer
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [2:0] code,
   output var  logic       step_tick
);
   logic [12:0]                   count;
   pmirq_pkg::pmirq_step_state_type state;

   // Code to cycle count; unlisted codes fall back to the default rate
   function automatic logic [12:0] step_cycles(input logic [2:0] c);
      unique case (c)
         `PMIRQ_STEP_30US: step_cycles = 13'(`PMIRQ_STEP_30_CYC);
         `PMIRQ_STEP_80US: step_cycles = 13'(`PMIRQ_STEP_80_CYC);
         default:          step_cycles = 13'(`PMIRQ_STEP_40_CYC);
      endcase
   endfunction : step_cycles

   // ==========================================================
   // Count one step period, then pulse
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state     <= pmirq_pkg::PMIRQ_ST_IDLE;
         count     <= 13'h0000;
         step_tick <= 1'b0;
      end
      else
      begin
         step_tick <= 1'b0;
         unique case (state)
            pmirq_pkg::PMIRQ_ST_IDLE:
            begin
               count <= 13'h0001;
               if (run)
                  state <= pmirq_pkg::PMIRQ_ST_COUNT;
            end
            pmirq_pkg::PMIRQ_ST_COUNT:
            begin
               if (!run)
                  state <= pmirq_pkg::PMIRQ_ST_IDLE;
               else if (count >= step_cycles(code))
               begin
                  state     <= pmirq_pkg::PMIRQ_ST_TICK;
                  step_tick <= 1'b1;
               end
               else
                  count <= count + 13'h0001;
            end
            pmirq_pkg::PMIRQ_ST_TICK:
            begin
               count <= 13'h0002;
               state <= run ? pmirq_pkg::PMIRQ_ST_COUNT : pmirq_pkg::PMIRQ_ST_IDLE;
            end
            default:
               state <= pmirq_pkg::PMIRQ_ST_IDLE;
         endcase
      end
   end
endmodule : pmirq_step_timer
`default_nettype wire

/* testbench/pmirq_host_model.sv */
// Host model: register master issuing write and read strobes
`default_nettype none
`include "pmirq_regs.svh"
module pmirq_host_model
(
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       fault_input_pin,
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Idle bus
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // ==========================================
   // Strobes held across exactly one rising edge
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(negedge ref_clk);
      reg_addr = addr;
      reg_wdata = data;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      // Scramble data so a stale value is never mistaken for a hold
      reg_wdata = ~data;
   endtask : wr
   // Data is registered at the strobe edge, so it is read a half cycle on
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(negedge ref_clk);
      reg_addr = addr;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      data = reg_rdata;
   endtask : rd
   task automatic release_latch();
      wait (fault_input_pin === 1'b1);
      wr(`PMIRQ_OFF_MODE_TWO, 8'h00);
   endtask : release_latch
endmodule : pmirq_host_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the interrupt, mask and mode register block
`default_nettype none
`include "pmirq_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Signals
   logic       ref_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] ev_one = 8'h00;
   logic [6:0] ev_two = 7'h00;
   logic [6:0] live = 7'h5a;
   logic       pin = 1'b1;
   logic       reg_wr, reg_rd, pin_en, bias, latch, ptick, ntick;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic [2:0] dis, rails, nstep, pstep;
   int         err_total = 0;
   int         num_checks = 0;
   // Clock, 20 ns period
   always #10 ref_clk = ~ref_clk;
   // ==========================================
   // Design and host
   pmirq_registers uut
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .fault_one_events(ev_one),
      .fault_two_events(ev_two), .live_status(live), .fault_input_pin(pin),
      .reg_rdata(reg_rdata), .fault_pin_enable(pin_en), .discharge_en(dis),
      .bias_enable(bias), .rail_enable(rails), .forced_shutdown_latch(latch),
      .neg_rail_step_time(nstep), .pos_rail_step_time(pstep),
      .pos_rail_step_tick(ptick), .neg_rail_step_tick(ntick)
   );
   pmirq_host_model host
   (
      .ref_clk(ref_clk), .reg_rdata(reg_rdata), .fault_input_pin(pin),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
   );
   // ==========================================
   // Compare and helper tasks
   task automatic stop_test();
      if (err_total == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_byte
   task automatic check_count(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_count
   task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
      host.rd(addr, rd);
      check_byte(rd, exp);
   endtask : read_check
   // Events last one cycle, so a flag seen later was held, not followed
   task automatic pulse(input logic [7:0] e1, input logic [6:0] e2);
      @(negedge ref_clk);
      ev_one = e1;
      ev_two = e2;
      @(negedge ref_clk);
      ev_one = 8'h00;
      ev_two = 7'h00;
   endtask : pulse
   task automatic pin_fall();
      @(negedge ref_clk);
      pin = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask : pin_fall
   // ==========================================
   // Scenarios
   task automatic t_reset();
      read_check(`PMIRQ_OFF_FLAGS_TWO, 8'h00);
      read_check(`PMIRQ_OFF_MASK_ONE, 8'h00);
      read_check(`PMIRQ_OFF_MASK_TWO, 8'h00);
      read_check(`PMIRQ_OFF_MODE_ONE, 8'h80);
      read_check(`PMIRQ_OFF_MODE_TWO, 8'h00);
      read_check(`PMIRQ_OFF_STEP_RATE, 8'h1b);
      read_check(8'h3c, 8'h00);
      check_byte({pin_en, dis, bias, rails}, 8'h80);
      check_byte({2'b00, nstep, pstep}, 8'h1b);
   endtask : t_reset
   task automatic t_flags_two();
      for (int i = 0; i < 7; i++)
      begin
         pulse(8'h00, 7'(1 << i));
         repeat (3) @(negedge ref_clk);
         read_check(`PMIRQ_OFF_FLAGS_TWO, 8'(2 << i));
         read_check(`PMIRQ_OFF_FLAGS_TWO, 8'h00);
      end
      // Event landing on the clearing edge must survive it
      fork
         host.rd(`PMIRQ_OFF_FLAGS_TWO, rd);
         pulse(8'h00, 7'h01);
      join
      check_byte(rd, 8'h00);
      read_check(`PMIRQ_OFF_FLAGS_TWO, 8'h02);
   endtask : t_flags_two
   task automatic t_fault_pin();
      pin_fall();
      check_byte({7'h00, latch}, 8'h01);
      read_check(`PMIRQ_OFF_STATUS_TWO, {live, 1'b0});
      read_check(`PMIRQ_OFF_FLAGS_TWO, 8'h01);
      host.wr(`PMIRQ_OFF_MODE_TWO, 8'h00);
      read_check(`PMIRQ_OFF_MODE_TWO, 8'h01);
      pin = 1'b1;
      host.release_latch();
      read_check(`PMIRQ_OFF_MODE_TWO, 8'h00);
      check_byte({7'h00, latch}, 8'h00);
      read_check(`PMIRQ_OFF_STATUS_TWO, {live, 1'b1});
   endtask : t_fault_pin
   task automatic t_masks();
      host.wr(`PMIRQ_OFF_MASK_TWO, 8'hff);
      read_check(`PMIRQ_OFF_MASK_TWO, 8'hff);
      pulse(8'h00, 7'h7f);
      pin_fall();
      pin = 1'b1;
      read_check(`PMIRQ_OFF_FLAGS_TWO, 8'h00);
      host.release_latch();
      host.wr(`PMIRQ_OFF_MASK_TWO, 8'hf0);
      pulse(8'h00, 7'h7f);
      read_check(`PMIRQ_OFF_FLAGS_TWO, 8'h0e);
      host.wr(`PMIRQ_OFF_MASK_ONE, 8'he0);
      pulse(8'hff, 7'h00);
      read_check(`PMIRQ_OFF_FLAGS_ONE, 8'h1f);
      host.wr(`PMIRQ_OFF_MASK_ONE, 8'h1f);
      pulse(8'hff, 7'h00);
      read_check(`PMIRQ_OFF_FLAGS_ONE, 8'he0);
   endtask : t_masks
   task automatic t_mode();
      host.wr(`PMIRQ_OFF_MODE_ONE, 8'h7f);
      read_check(`PMIRQ_OFF_MODE_ONE, 8'h7f);
      check_byte({pin_en, dis, bias, rails}, 8'h7f);
      pin_fall();
      pin = 1'b1;
      read_check(`PMIRQ_OFF_FLAGS_TWO, 8'h00);
      check_byte({7'h00, latch}, 8'h00);
      host.wr(`PMIRQ_OFF_STEP_RATE, 8'hd3);
      read_check(`PMIRQ_OFF_STEP_RATE, 8'hd3);
      check_byte({2'b00, nstep, pstep}, 8'h13);
      host.wr(`PMIRQ_OFF_MODE_TWO, 8'h7e);
      read_check(`PMIRQ_OFF_MODE_TWO, 8'h7e);
   endtask : t_mode
   // Period between two ticks, bounded so a dead timer cannot hang
   task automatic measure(input logic pos, input logic [15:0] exp);
      logic [15:0] n;
      n = 16'h0000;
      while ((pos ? ptick : ntick) !== 1'b1 && n < 16'h2400)
      begin
         @(negedge ref_clk);
         n++;
      end
      n = 16'h0000;
      do
      begin
         @(negedge ref_clk);
         n++;
      end
      while ((pos ? ptick : ntick) !== 1'b1 && n < 16'h2400);
      check_count(n, exp);
   endtask : measure
   task automatic t_steps();
      measure(1'b1, 16'(`PMIRQ_STEP_40_CYC));
      measure(1'b0, 16'(`PMIRQ_STEP_30_CYC));
      host.wr(`PMIRQ_OFF_STEP_RATE, 8'h3b);
      measure(1'b0, 16'(`PMIRQ_STEP_80_CYC));
      // Slowest code on the positive rail as well
      host.wr(`PMIRQ_OFF_STEP_RATE, 8'h3f);
      measure(1'b1, 16'(`PMIRQ_STEP_80_CYC));
   endtask : t_steps
   task automatic t_soft_reset();
      logic [7:0] offs [7];
      logic [7:0] exps [7];
      offs = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11};
      exps = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h1b};
      pulse(8'h01, 7'h01);
      host.wr(`PMIRQ_OFF_MODE_TWO, 8'h80);
      @(negedge ref_clk);
      check_byte({pin_en, dis, bias, rails}, 8'h80);
      check_byte({2'b00, nstep, pstep}, 8'h1b);
      for (int i = 0; i < 7; i++)
         read_check(offs[i], exps[i]);
   endtask : t_soft_reset
   // ==========================================
   // Main sequence and watchdog
   initial
   begin
      repeat (16) @(negedge ref_clk);
      rst_n = 1'b1;
      t_reset();
      t_flags_two();
      t_fault_pin();
      t_masks();
      t_mode();
      t_steps();
      t_soft_reset();
      stop_test();
   end
   // Tests take about 22000 cycles; nearly three times that means a hang
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      err_total++;
      stop_test();
   end
endmodule : testbench
`default_nettype wire
